/* File: hdl/piec_pkg.sv */
// Shared constants and types for the information element codec
package piec_pkg;

   // ---------------------------------------------------------------
   // Field widths, in bits
   // ---------------------------------------------------------------
   localparam int PIEC_W_URG = 2;
   localparam int PIEC_W_ACK = 1;
   localparam int PIEC_W_CC = 10;
   localparam int PIEC_W_NC = 14;
   localparam int PIEC_W_AREA = 4;
   localparam int PIEC_W_ATT = 3;
   localparam int PIEC_W_CMT = 3;
   localparam int PIEC_W_E2E = 1;
   localparam int PIEC_W_COMM = 2;
   localparam int PIEC_W_SLOT = 2;
   localparam int PIEC_W_DATA = PIEC_W_CC + PIEC_W_NC;
   localparam int PIEC_W_LEN = 5;

   // ---------------------------------------------------------------
   // Element lengths and field positions
   // ---------------------------------------------------------------
   localparam logic [4:0] PIEC_LEN_URG = 5'h02;
   localparam logic [4:0] PIEC_LEN_ACK = 5'h01;
   localparam logic [4:0] PIEC_LEN_ADDR = 5'h18;
   localparam logic [4:0] PIEC_LEN_AREA = 5'h04;
   localparam logic [4:0] PIEC_LEN_ATT = 5'h03;
   localparam logic [4:0] PIEC_LEN_BASIC = 5'h08;
   localparam int PIEC_POS_CMT = 5;
   localparam int PIEC_POS_E2E = 4;
   localparam int PIEC_POS_COMM = 2;
   localparam int PIEC_POS_SLOT = 0;
   localparam int PIEC_POS_CC = PIEC_W_NC;

   // ---------------------------------------------------------------
   // Code points
   // ---------------------------------------------------------------
   localparam logic [1:0] PIEC_URG_LOW = 2'h0;
   localparam logic [1:0] PIEC_URG_HIGH = 2'h1;
   localparam logic [1:0] PIEC_URG_EMERG = 2'h2;
   localparam logic [1:0] PIEC_URG_RSVD = 2'h3;
   localparam logic [3:0] PIEC_AREA_UNDEF = 4'h0;
   localparam logic [3:0] PIEC_AREA_ALL = 4'hf;
   localparam logic [2:0] PIEC_ATT_NONE = 3'h0;
   localparam logic [2:0] PIEC_ATT_UNSUPP = 3'h7;
   localparam logic [2:0] PIEC_CMT_SPEECH = 3'h0;
   localparam logic [2:0] PIEC_CMT_UNPROT = 3'h1;
   localparam logic [2:0] PIEC_CMT_LOW_N1 = 3'h2;
   localparam logic [2:0] PIEC_CMT_HIGH_N1 = 3'h5;
   localparam logic [2:0] PIEC_CMT_HIGH_N8 = 3'h7;
   localparam logic [1:0] PIEC_SLOT_ZERO = 2'h0;
   localparam logic [2:0] PIEC_SLOT_BIAS = 3'h1;

   // Container types 1, 2 and 3; zero is not a container
   localparam logic [1:0] PIEC_CT_NONE = 2'h0;

   typedef enum logic [2:0] {
      PIEC_EL_URG,
      PIEC_EL_ACK,
      PIEC_EL_ADDR,
      PIEC_EL_AREA,
      PIEC_EL_ATT,
      PIEC_EL_BASIC
   } piec_elem_t;

   typedef struct packed {
      logic [PIEC_W_URG-1:0] access_urgency;
      logic ack_required;
      logic [PIEC_W_CC-1:0] country_code_field;
      logic [PIEC_W_NC-1:0] network_code_field;
      logic [PIEC_W_AREA-1:0] distribution_area_select;
      logic [PIEC_W_ATT-1:0] attach_status;
      logic [PIEC_W_CMT-1:0] circuit_mode;
      logic e2e_encrypt;
      logic [PIEC_W_COMM-1:0] comm_type;
      logic [PIEC_W_SLOT-1:0] slot_code;
   } piec_fields_t;

   // Slots per frame as a count of one to four
   function automatic logic [2:0] piec_slot_count(input logic [1:0] code);
      piec_slot_count = {1'b0, code} + PIEC_SLOT_BIAS;
   endfunction : piec_slot_count

   function automatic logic piec_is_data(input logic [2:0] cmt);
      piec_is_data = (cmt != PIEC_CMT_SPEECH);
   endfunction : piec_is_data

endpackage : piec_pkg

/* File: hdl/piec_elem_if.sv */
// Interface between the codec top and its packer and checker
`timescale 1ns/1ps
`default_nettype none
interface piec_elem_if;
   import piec_pkg::*;
   piec_elem_t elem;
   piec_fields_t fields;
   logic [PIEC_W_DATA-1:0] data;
   logic [PIEC_W_LEN-1:0] len;
   logic bad;

   modport pack (input elem, input fields, output data, output len,
      output bad);
   modport unpack (input elem, input data, output fields, output len,
      output bad);
endinterface : piec_elem_if
`default_nettype wire

/* File: hdl/piec_packer.sv */
// Field packer: fields to an LSB-aligned element word
`timescale 1ns/1ps
`default_nettype none
module piec_packer (
   piec_elem_if.pack p
);
   import piec_pkg::*;

   always_comb
   begin
      p.data = '0;
      p.len = PIEC_LEN_URG;
      p.bad = 1'b0;
      unique case (p.elem)
         PIEC_EL_URG:
         begin
            p.data[PIEC_W_URG-1:0] = p.fields.access_urgency;
            p.bad = (p.fields.access_urgency == PIEC_URG_RSVD);
         end
         PIEC_EL_ACK:
         begin
            p.data[0] = p.fields.ack_required;
            p.len = PIEC_LEN_ACK;
         end
         PIEC_EL_ADDR:
         begin
            p.data = {p.fields.country_code_field,
               p.fields.network_code_field};
            p.len = PIEC_LEN_ADDR;
         end
         PIEC_EL_AREA:
         begin
            p.data[PIEC_W_AREA-1:0] = p.fields.distribution_area_select;
            p.len = PIEC_LEN_AREA;
         end
         PIEC_EL_ATT:
         begin
            p.data[PIEC_W_ATT-1:0] = p.fields.attach_status;
            p.len = PIEC_LEN_ATT;
         end
         PIEC_EL_BASIC:
         begin
            p.data[PIEC_POS_CMT+:PIEC_W_CMT] = p.fields.circuit_mode;
            p.data[PIEC_POS_E2E] = p.fields.e2e_encrypt;
            p.data[PIEC_POS_COMM+:PIEC_W_COMM] = p.fields.comm_type;
            // Speech keeps the slot field, forced to zero
            p.data[PIEC_POS_SLOT+:PIEC_W_SLOT] =
               piec_is_data(p.fields.circuit_mode) ?
               p.fields.slot_code : PIEC_SLOT_ZERO;
            p.len = PIEC_LEN_BASIC;
         end
         default:
            p.bad = 1'b1;
      endcase
   end

endmodule : piec_packer
`default_nettype wire

/* File: hdl/piec_checker.sv */
// Field checker: element word back to raw fields, reserved codes flagged
`timescale 1ns/1ps
`default_nettype none
module piec_checker (
   piec_elem_if.unpack u
);
   import piec_pkg::*;

   always_comb
   begin
      u.fields = '0;
      u.len = PIEC_LEN_URG;
      u.bad = 1'b0;
      unique case (u.elem)
         PIEC_EL_URG:
         begin
            u.fields.access_urgency = u.data[PIEC_W_URG-1:0];
            u.bad = (u.data[PIEC_W_URG-1:0] == PIEC_URG_RSVD);
         end
         PIEC_EL_ACK:
         begin
            u.fields.ack_required = u.data[0];
            u.len = PIEC_LEN_ACK;
         end
         PIEC_EL_ADDR:
         begin
            u.fields.country_code_field = u.data[PIEC_POS_CC+:PIEC_W_CC];
            u.fields.network_code_field = u.data[PIEC_W_NC-1:0];
            u.len = PIEC_LEN_ADDR;
         end
         PIEC_EL_AREA:
         begin
            u.fields.distribution_area_select = u.data[PIEC_W_AREA-1:0];
            u.len = PIEC_LEN_AREA;
         end
         PIEC_EL_ATT:
         begin
            u.fields.attach_status = u.data[PIEC_W_ATT-1:0];
            u.len = PIEC_LEN_ATT;
         end
         PIEC_EL_BASIC:
         begin
            u.fields.circuit_mode = u.data[PIEC_POS_CMT+:PIEC_W_CMT];
            u.fields.e2e_encrypt = u.data[PIEC_POS_E2E];
            u.fields.comm_type = u.data[PIEC_POS_COMM+:PIEC_W_COMM];
            u.fields.slot_code = u.data[PIEC_POS_SLOT+:PIEC_W_SLOT];
            u.len = PIEC_LEN_BASIC;
            // Speech with a non-zero slot field is flagged, raw kept
            u.bad = !piec_is_data(u.data[PIEC_POS_CMT+:PIEC_W_CMT]) &&
               (u.data[PIEC_POS_SLOT+:PIEC_W_SLOT] != PIEC_SLOT_ZERO);
         end
         default:
            u.bad = 1'b1;
      endcase
   end

endmodule : piec_checker
`default_nettype wire

/* File: hdl/piec_codec.sv */
// Information element codec top: registered encode and decode paths
`timescale 1ns/1ps
`default_nettype none
module piec_codec (
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Encode request
   input wire logic i_enc_valid,
   input wire piec_pkg::piec_elem_t i_enc_elem,
   input wire logic [1:0] i_enc_container,
   input wire logic [piec_pkg::PIEC_W_URG-1:0] i_access_urgency,
   input wire logic i_ack_required,
   input wire logic [piec_pkg::PIEC_W_CC-1:0] i_country_code_field,
   input wire logic [piec_pkg::PIEC_W_NC-1:0] i_network_code_field,
   input wire logic [piec_pkg::PIEC_W_AREA-1:0] i_distribution_area_select,
   input wire logic [piec_pkg::PIEC_W_ATT-1:0] i_attach_status,
   input wire logic [piec_pkg::PIEC_W_CMT-1:0] i_circuit_mode,
   input wire logic i_e2e_encrypt,
   input wire logic [piec_pkg::PIEC_W_COMM-1:0] i_comm_type,
   input wire logic [piec_pkg::PIEC_W_SLOT-1:0] i_slot_code,
   // Encode answer
   output logic o_enc_valid,
   output logic o_enc_reject,
   output logic [piec_pkg::PIEC_W_DATA-1:0] o_enc_data,
   output logic [piec_pkg::PIEC_W_LEN-1:0] o_enc_len,
   output logic [1:0] o_enc_container,
   // Decode request
   input wire logic i_dec_valid,
   input wire piec_pkg::piec_elem_t i_dec_elem,
   input wire logic [1:0] i_dec_container,
   input wire logic [piec_pkg::PIEC_W_DATA-1:0] i_dec_data,
   // Decode answer
   output logic o_dec_valid,
   output logic o_dec_error,
   output piec_pkg::piec_elem_t o_dec_elem,
   output logic [1:0] o_dec_container,
   output logic [piec_pkg::PIEC_W_DATA-1:0] o_dec_raw,
   output logic [piec_pkg::PIEC_W_LEN-1:0] o_dec_len,
   output piec_pkg::piec_fields_t o_dec_fields,
   output logic [2:0] o_dec_slot_count,
   output logic o_dec_data_channel,
   output logic o_dec_all_areas
);
   import piec_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic enc_valid;
      logic enc_reject;
      logic [PIEC_W_DATA-1:0] enc_data;
      logic [PIEC_W_LEN-1:0] enc_len;
      logic [1:0] enc_cont;
      logic dec_valid;
      logic dec_error;
      piec_elem_t dec_elem;
      logic [1:0] dec_cont;
      logic [PIEC_W_DATA-1:0] dec_raw;
      logic [PIEC_W_LEN-1:0] dec_len;
      piec_fields_t dec_fields;
      logic [2:0] dec_slots;
      logic dec_data_ch;
      logic dec_all_areas;
   } piec_state_t;

   piec_state_t st_r;
   piec_state_t st_nxt;
   piec_fields_t enc_fields;

   piec_elem_if enc_if ();
   piec_elem_if dec_if ();

   // ---------------------------------------------------------------
   // Packer and checker
   // ---------------------------------------------------------------
   always_comb
   begin
      enc_fields.access_urgency = i_access_urgency;
      enc_fields.ack_required = i_ack_required;
      enc_fields.country_code_field = i_country_code_field;
      enc_fields.network_code_field = i_network_code_field;
      enc_fields.distribution_area_select = i_distribution_area_select;
      enc_fields.attach_status = i_attach_status;
      enc_fields.circuit_mode = i_circuit_mode;
      enc_fields.e2e_encrypt = i_e2e_encrypt;
      enc_fields.comm_type = i_comm_type;
      enc_fields.slot_code = i_slot_code;
   end

   assign enc_if.elem = i_enc_elem;
   assign enc_if.fields = enc_fields;
   assign dec_if.elem = i_dec_elem;
   assign dec_if.data = i_dec_data;

   piec_packer u_packer (
      .p (enc_if)
   );

   piec_checker u_checker (
      .u (dec_if)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // Valid and reject answers stand one cycle; dec_error and data fields hold until the next decode or accepted encode
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.enc_valid = 1'b0;
      st_nxt.enc_reject = 1'b0;
      st_nxt.dec_valid = 1'b0;
      if (i_enc_valid)
      begin
         // A word is never emitted partly legal; refuse it whole
         if (enc_if.bad || i_enc_container == PIEC_CT_NONE)
         begin
            st_nxt.enc_reject = 1'b1;
         end
         else
         begin
            st_nxt.enc_valid = 1'b1;
            st_nxt.enc_data = enc_if.data;
            st_nxt.enc_len = enc_if.len;
            st_nxt.enc_cont = i_enc_container;
         end
      end
      if (i_dec_valid)
      begin
         st_nxt.dec_valid = 1'b1;
         st_nxt.dec_error = dec_if.bad ||
            (i_dec_container == PIEC_CT_NONE);
         st_nxt.dec_elem = i_dec_elem;
         st_nxt.dec_cont = i_dec_container;
         st_nxt.dec_raw = i_dec_data;
         st_nxt.dec_len = dec_if.len;
         st_nxt.dec_fields = dec_if.fields;
         st_nxt.dec_slots = piec_slot_count(dec_if.fields.slot_code);
         st_nxt.dec_data_ch = (i_dec_elem == PIEC_EL_BASIC) &&
            piec_is_data(dec_if.fields.circuit_mode);
         st_nxt.dec_all_areas = (i_dec_elem == PIEC_EL_AREA) &&
            (dec_if.fields.distribution_area_select == PIEC_AREA_ALL);
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_enc_valid = st_r.enc_valid;
   assign o_enc_reject = st_r.enc_reject;
   assign o_enc_data = st_r.enc_data;
   assign o_enc_len = st_r.enc_len;
   assign o_enc_container = st_r.enc_cont;
   assign o_dec_valid = st_r.dec_valid;
   assign o_dec_error = st_r.dec_error;
   assign o_dec_elem = st_r.dec_elem;
   assign o_dec_container = st_r.dec_cont;
   assign o_dec_raw = st_r.dec_raw;
   assign o_dec_len = st_r.dec_len;
   assign o_dec_fields = st_r.dec_fields;
   assign o_dec_slot_count = st_r.dec_slots;
   assign o_dec_data_channel = st_r.dec_data_ch;
   assign o_dec_all_areas = st_r.dec_all_areas;

endmodule : piec_codec
`default_nettype wire

/* File: testbench/piec_codec_asserts.sv */
// Assertion checker bound to the information element codec top
`timescale 1ns/1ps
`default_nettype none
module piec_codec_asserts
   import piec_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_enc_valid,
   input wire piec_pkg::piec_elem_t i_enc_elem,
   input wire logic [1:0] i_enc_container,
   input wire logic [piec_pkg::PIEC_W_URG-1:0] i_access_urgency,
   input wire logic [piec_pkg::PIEC_W_CC-1:0] i_country_code_field,
   input wire logic [piec_pkg::PIEC_W_NC-1:0] i_network_code_field,
   input wire logic [piec_pkg::PIEC_W_CMT-1:0] i_circuit_mode,
   input wire logic i_e2e_encrypt,
   input wire logic [piec_pkg::PIEC_W_COMM-1:0] i_comm_type,
   input wire logic [piec_pkg::PIEC_W_SLOT-1:0] i_slot_code,
   input wire logic o_enc_valid,
   input wire logic o_enc_reject,
   input wire logic [piec_pkg::PIEC_W_DATA-1:0] o_enc_data,
   input wire logic [piec_pkg::PIEC_W_LEN-1:0] o_enc_len,
   input wire logic i_dec_valid,
   input wire piec_pkg::piec_elem_t i_dec_elem,
   input wire logic [piec_pkg::PIEC_W_DATA-1:0] i_dec_data,
   input wire logic o_dec_valid,
   input wire logic o_dec_error,
   input wire logic [piec_pkg::PIEC_W_DATA-1:0] o_dec_raw,
   input wire piec_pkg::piec_elem_t o_dec_elem,
   input wire piec_pkg::piec_fields_t o_dec_fields,
   input wire logic o_dec_all_areas
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // ------------------------------------------------------------
   // Encode path
   // ------------------------------------------------------------
   sequence s_take;
      i_enc_valid && i_enc_container != 2'h0;
   endsequence
   sequence s_done;
      ##1 o_enc_valid && !o_enc_reject;
   endsequence
   property p_enc_answer;
      i_enc_valid |=> o_enc_valid ^ o_enc_reject;
   endproperty
   a_enc_answer: assert property (p_enc_answer)
      else $error("encode answer missing or doubled");
   property p_urg_refuse;
      s_take ##0 (i_enc_elem == PIEC_EL_URG && i_access_urgency == 2'h3)
         |=> o_enc_reject && $stable(o_enc_data);
   endproperty
   a_urg_refuse: assert property (p_urg_refuse)
      else $error("reserved urgency not refused");
   property p_cont_refuse;
      i_enc_valid && i_enc_container == 2'h0 |=> o_enc_reject;
   endproperty
   a_cont_refuse: assert property (p_cont_refuse)
      else $error("container zero not refused");
   property p_addr_pack;
      s_take ##0 i_enc_elem == PIEC_EL_ADDR |-> s_done ##0
         (o_enc_len == 5'h18 && o_enc_data ==
         {$past(i_country_code_field), $past(i_network_code_field)});
   endproperty
   a_addr_pack: assert property (p_addr_pack)
      else $error("address word wrong");
   property p_basic_pack;
      s_take ##0 i_enc_elem == PIEC_EL_BASIC |-> s_done ##0
         (o_enc_len == 5'h08 && o_enc_data[23:2] == {16'h0,
         $past(i_circuit_mode), $past(i_e2e_encrypt), $past(i_comm_type)});
   endproperty
   a_basic_pack: assert property (p_basic_pack)
      else $error("basic service word wrong");
   property p_speech_slot;
      s_take ##0 i_enc_elem == PIEC_EL_BASIC |=> o_enc_data[1:0] ==
         ($past(i_circuit_mode) == 3'h0 ? 2'h0 : $past(i_slot_code));
   endproperty
   a_speech_slot: assert property (p_speech_slot)
      else $error("slot field wrong");
   // ------------------------------------------------------------
   // Decode path
   // ------------------------------------------------------------
   property p_dec_pass;
      i_dec_valid |=> o_dec_valid && o_dec_raw == $past(i_dec_data);
   endproperty
   a_dec_pass: assert property (p_dec_pass)
      else $error("raw word not passed");
   property p_dec_urg;
      i_dec_valid && i_dec_elem == PIEC_EL_URG && i_dec_data[1:0] == 2'h3
         |=> o_dec_error;
   endproperty
   a_dec_urg: assert property (p_dec_urg)
      else $error("reserved urgency not flagged");
   property p_dec_speech;
      i_dec_valid && i_dec_elem == PIEC_EL_BASIC && i_dec_data[7:5] == 3'h0
         && i_dec_data[1:0] != 2'h0 |=> o_dec_error;
   endproperty
   a_dec_speech: assert property (p_dec_speech)
      else $error("speech slots not flagged");
   property p_all_areas;
      o_dec_valid |-> o_dec_all_areas == (o_dec_elem == PIEC_EL_AREA
         && o_dec_fields.distribution_area_select == 4'hf);
   endproperty
   a_all_areas: assert property (p_all_areas)
      else $error("all areas flag wrong");
endmodule : piec_codec_asserts
bind piec_codec piec_codec_asserts u_piec_codec_asserts (.i_core_clk,
   .i_rst, .i_enc_valid, .i_enc_elem, .i_enc_container, .i_access_urgency,
   .i_country_code_field, .i_network_code_field, .i_circuit_mode,
   .i_e2e_encrypt, .i_comm_type, .i_slot_code, .o_enc_valid, .o_enc_reject,
   .o_enc_data, .o_enc_len, .i_dec_valid, .i_dec_elem, .i_dec_data,
   .o_dec_valid, .o_dec_error, .o_dec_raw, .o_dec_elem, .o_dec_fields,
   .o_dec_all_areas);
`default_nettype wire

/* File: testbench/piec_peer.sv */
// Peer model that sends element words into the decode path
`timescale 1ns/1ps
`default_nettype none
module piec_peer
   import piec_pkg::*;
(
   input wire logic i_core_clk,
   output var logic o_valid,
   output var piec_pkg::piec_elem_t o_elem,
   output var logic [1:0] o_container,
   output var logic [piec_pkg::PIEC_W_DATA-1:0] o_data
);
   initial
   begin
      o_valid = 1'b0;
      o_elem = PIEC_EL_URG;
      o_container = 2'h1;
      o_data = '0;
   end
   // LSB-aligned word, container picked per PDU
   task automatic send(input piec_elem_t e, input logic [1:0] c,
      input logic [PIEC_W_DATA-1:0] d);
      o_valid = 1'b1;
      o_elem = e;
      o_container = c;
      o_data = d;
      @(posedge i_core_clk);
      #1;
   endtask : send
   // Released line shows the inverse, never a stale copy
   task automatic quiet();
      o_valid = 1'b0;
      o_data = ~o_data;
   endtask : quiet
endmodule : piec_peer
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking testbench for the information element codec
`timescale 1ns/1ps
`default_nettype none
module tb;
   import piec_pkg::*;
   logic i_core_clk, i_rst, i_enc_valid, i_dec_valid;
   piec_elem_t i_enc_elem, i_dec_elem, o_dec_elem;
   logic [1:0] i_enc_container, i_dec_container;
   logic [1:0] o_enc_container, o_dec_container;
   piec_fields_t f, o_dec_fields;
   logic o_enc_valid, o_enc_reject, o_dec_valid, o_dec_error;
   logic o_dec_data_channel, o_dec_all_areas;
   logic [23:0] o_enc_data, i_dec_data, o_dec_raw, last_enc;
   logic [4:0] o_enc_len, o_dec_len;
   logic [2:0] o_dec_slot_count;
   int miscompares, compares;
   piec_codec u_piec_codec (.i_core_clk, .i_rst, .i_enc_valid, .i_enc_elem,
      .i_enc_container, .i_access_urgency(f.access_urgency),
      .i_ack_required(f.ack_required),
      .i_country_code_field(f.country_code_field),
      .i_network_code_field(f.network_code_field),
      .i_distribution_area_select(f.distribution_area_select),
      .i_attach_status(f.attach_status), .i_circuit_mode(f.circuit_mode),
      .i_e2e_encrypt(f.e2e_encrypt), .i_comm_type(f.comm_type),
      .i_slot_code(f.slot_code), .o_enc_valid, .o_enc_reject, .o_enc_data,
      .o_enc_len, .o_enc_container, .i_dec_valid, .i_dec_elem,
      .i_dec_container, .i_dec_data, .o_dec_valid, .o_dec_error,
      .o_dec_elem, .o_dec_container, .o_dec_raw, .o_dec_len, .o_dec_fields,
      .o_dec_slot_count, .o_dec_data_channel, .o_dec_all_areas);
   piec_peer u_piec_peer (.i_core_clk, .o_valid(i_dec_valid),
      .o_elem(i_dec_elem), .o_container(i_dec_container),
      .o_data(i_dec_data));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask : chk
   // Leaves the request up so calls run back to back
   task automatic enc(input piec_elem_t e, input logic [1:0] c,
      input logic rej, input logic [23:0] d, input logic [4:0] n);
      i_enc_valid = 1'b1;
      i_enc_elem = e;
      i_enc_container = c;
      @(posedge i_core_clk);
      #1;
      chk(o_enc_reject, rej);
      chk(o_enc_valid, !rej);
      chk(o_enc_data, rej ? last_enc : d);
      if (!rej)
      begin
         chk(o_enc_len, n);
         chk(o_enc_container, c);
         last_enc = d;
      end
   endtask : enc
   task automatic enc_idle();
      i_enc_valid = 1'b0;
      @(posedge i_core_clk);
      #1;
      chk({o_enc_valid, o_enc_reject}, 2'h0);
   endtask : enc_idle
   task automatic dec(input piec_elem_t e, input logic [1:0] c,
      input logic [23:0] d, input logic err);
      u_piec_peer.send(e, c, d);
      chk({o_dec_valid, o_dec_error}, {1'b1, err});
      chk(o_dec_raw, d);
      chk(o_dec_container, c);
      chk(o_dec_elem, e);
   endtask : dec
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_short();
      for (int u = 0; u < 4; u++)
      begin
         f.access_urgency = u[1:0];
         enc(PIEC_EL_URG, 2'(u % 3 + 1), u == 3, 24'(u), 5'h02);
      end
      for (int a = 0; a < 2; a++)
      begin
         f.ack_required = a[0];
         enc(PIEC_EL_ACK, 2'h2, 1'b0, 24'(a), 5'h01);
      end
      for (int v = 0; v < 16; v++)
      begin
         f.distribution_area_select = v[3:0];
         enc(PIEC_EL_AREA, 2'h3, 1'b0, 24'(v), 5'h04);
      end
      for (int v = 0; v < 8; v++)
      begin
         f.attach_status = v[2:0];
         enc(PIEC_EL_ATT, 2'h1, 1'b0, 24'(v), 5'h03);
      end
      f.country_code_field = 10'h2a5;
      f.network_code_field = 14'h1c3b;
      enc(PIEC_EL_ADDR, 2'h2, 1'b0, {10'h2a5, 14'h1c3b}, 5'h18);
      enc_idle();
   endtask : s_short
   task automatic s_basic();
      logic [1:0] s;
      for (int m = 0; m < 8; m++)
         for (int k = 0; k < 4; k++)
         begin
            s = (m == 0) ? 2'h0 : k[1:0];
            f.circuit_mode = m[2:0];
            f.slot_code = k[1:0];
            f.e2e_encrypt = k[0];
            f.comm_type = 2'(m + k);
            enc(PIEC_EL_BASIC, 2'h2, 1'b0, {16'h0, m[2:0], k[0],
               2'(m + k), s}, 5'h08);
         end
      f.access_urgency = 2'h0;
      enc(PIEC_EL_URG, 2'h0, 1'b1, 24'h0, 5'h02);
      enc(piec_elem_t'(3'h6), 2'h1, 1'b1, 24'h0, 5'h02);
      enc(piec_elem_t'(3'h7), 2'h1, 1'b1, 24'h0, 5'h02);
      enc_idle();
   endtask : s_basic
   task automatic s_dec();
      dec(PIEC_EL_URG, 2'h1, 24'h3, 1'b1);
      chk(o_dec_fields.access_urgency, 2'h3);
      dec(PIEC_EL_URG, 2'h2, 24'hfffffe, 1'b0);
      chk({o_dec_len, o_dec_fields.access_urgency}, {5'h02, 2'h2});
      dec(PIEC_EL_BASIC, 2'h3, 24'h00001a, 1'b1);
      dec(PIEC_EL_BASIC, 2'h1, 24'h0000ae, 1'b0);
      chk({o_dec_slot_count, o_dec_data_channel}, {3'h3, 1'b1});
      chk(o_dec_fields.comm_type, 2'h3);
      dec(PIEC_EL_AREA, 2'h1, 24'h00000f, 1'b0);
      chk(o_dec_all_areas, 1'b1);
      dec(PIEC_EL_ADDR, 2'h2, {10'h155, 14'h2aaa}, 1'b0);
      chk(o_dec_fields.country_code_field, 10'h155);
      chk(o_dec_fields.network_code_field, 14'h2aaa);
      dec(PIEC_EL_ATT, 2'h0, 24'h000007, 1'b1);
      chk(o_dec_fields.attach_status, 3'h7);
      dec(PIEC_EL_ACK, 2'h3, 24'hfffff1, 1'b0);
      chk({o_dec_len, o_dec_fields.ack_required}, {5'h01, 1'b1});
      dec(piec_elem_t'(3'h7), 2'h1, 24'h000000, 1'b1);
      u_piec_peer.quiet();
      @(posedge i_core_clk);
      #1;
      chk(o_dec_valid, 1'b0);
   endtask : s_dec
   task automatic s_reset();
      i_rst = 1'b1;
      repeat (4) @(posedge i_core_clk);
      #1;
      chk({o_enc_data, o_dec_raw, o_dec_error}, 49'h0);
      i_rst = 1'b0;
      last_enc = '0;
   endtask : s_reset
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // ------------------------------------------------------------
   // Clock, sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      i_core_clk = 1'b0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end
   initial
   begin
      i_rst = 1'b1;
      i_enc_valid = 1'b0;
      i_enc_elem = PIEC_EL_URG;
      i_enc_container = 2'h1;
      f = '0;
      last_enc = '0;
      miscompares = 0;
      compares = 0;
      repeat (4) @(posedge i_core_clk);
      #1;
      i_rst = 1'b0;
      s_short();
      s_dec();
      s_reset();
      s_basic();
      stop_test();
   end
   // About 86 cycles expected; generous margin
   initial
   begin
      repeat (2000) @(posedge i_core_clk);
      miscompares++;
      stop_test();
   end
endmodule : tb
`default_nettype wire
